// file: fb_consts.svh
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: 25 MHz pclk, 32-bit APB data
// Notes: definitions only
`ifndef FB_CONSTS_SVH
`define FB_CONSTS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define ADDR_CTRL 12'h000
`define ADDR_STATE 12'h004
`define ADDR_EXPECT 12'h008
`define ADDR_STATUS 12'h00C
`define WIN_BASE_NIB 4'h1

// ************************************************************
// field positions
// ************************************************************
`define CTRL_RATE_LSB 0
`define CTRL_MODE_LSB 4
`define CTRL_OS_LSB 8
`define CTRL_MASK_LSB 16
`define STATE_REQ_LSB 0
`define STATE_RED_LSB 8
`define STAT_INCONS_BIT 0
`define STAT_SMERR_BIT 1
`define STAT_READY_BIT 2
`define STAT_WORDS_LSB 8
`define STAT_SEQ_LSB 16

// ************************************************************
// reset values
// ************************************************************
`define RST_RATE 3'h3
`define RST_OS 5'h01
`define RST_MASK 4'h1

// ************************************************************
// timing
// ************************************************************
`define PCLK_HZ 25000000
`define PCLK_NS 40
`define RATE_0_HZ 1500
`define RATE_1_HZ 2500
`define RATE_2_HZ 5000
`define RATE_3_HZ 10000
`define RATE_4_HZ 20000
`define RATE_5_HZ 30000
`define RATE_6_HZ 49140
`define FULL_RATE_IDX 3'h3
`define SYNC_TOL_CYC 16'h0002
`define DEC_ONE_20K 3'h1
`define DEC_ONE_30K 3'h2
`define DEC_ONE_49K 3'h3
`define DEC_MANY_20K 3'h2
`define DEC_MANY_30K 3'h3
`define DEC_MANY_49K 3'h5
`define LED_TICK_MS 50
`define LED_ON_MS 200
`define LED_SINGLE_OFF_MS 1000
`define LED_DOUBLE_OFF_MS 400
`define LED_FAST_HALF_MS 50
`define LED_WRAP_TICKS 7'h78

`endif

// file: fb_pkg.sv
// Purpose: shared types of the oversampling framer
// Assumes: nothing
// Notes: constants live in fb_consts.svh
package fb_pkg;

  typedef enum logic [1:0] {
    free_running_mode = 2'b00,
    clock_synchronous_mode = 2'b01,
    alternating_phase_one_mode = 2'b10,
    alternating_phase_two_mode = 2'b11
  } sync_mode_t;

  typedef enum logic [1:0] {
    st_init = 2'b00,
    st_preop = 2'b01,
    st_safeop = 2'b10,
    st_op = 2'b11
  } bus_state_t;

  typedef enum logic [2:0] {
    pat_off = 3'b000,
    pat_on = 3'b001,
    pat_slow = 3'b010,
    pat_fast = 3'b011,
    pat_single = 3'b100,
    pat_double = 3'b101
  } led_pat_t;

  // value i of a record sits at bits [32*i +: 32]; i = 0 is distance
  typedef struct packed {
    logic [31:0] stamp;
    logic [31:0] counter;
    logic [31:0] intensity;
    logic [31:0] distance;
  } record_t;

  typedef struct packed {
    logic green;
    logic red;
  } led_t;

endpackage

// file: fieldbus_oversample_sync.sv
// Purpose: oversampling block framer, sync modes and state indicator
// Assumes: sync0 and meas_valid are one-cycle pulses on pclk
// Notes: APB slave, one wait state on every transfer
`timescale 1ns/100ps
`include "fb_consts.svh"

module fieldbus_oversample_sync
  import fb_pkg::*;
#(
  parameter int MAX_OS = 16,
  parameter int LED_TICK_CYC =
    `LED_TICK_MS * (1000000 / `PCLK_NS)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync0,
  input wire logic meas_valid,
  input wire record_t meas_record,
  output logic laser_fire,
  output logic ext_sync_oe,
  output led_t leds
);

  localparam int NVAL = 4;
  localparam int BUF_WORDS = MAX_OS * NVAL;
  localparam int AW = $clog2(BUF_WORDS);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [15:0] rate_period(input logic [2:0] r);
    case (r)
      3'h0: rate_period = 16'(`PCLK_HZ / `RATE_0_HZ);
      3'h1: rate_period = 16'(`PCLK_HZ / `RATE_1_HZ);
      3'h2: rate_period = 16'(`PCLK_HZ / `RATE_2_HZ);
      3'h3: rate_period = 16'(`PCLK_HZ / `RATE_3_HZ);
      3'h4: rate_period = 16'(`PCLK_HZ / `RATE_4_HZ);
      3'h5: rate_period = 16'(`PCLK_HZ / `RATE_5_HZ);
      default: rate_period = 16'(`PCLK_HZ / `RATE_6_HZ);
    endcase
  endfunction

  function automatic logic [2:0] popcount(input logic [3:0] m);
    popcount = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction

  function automatic logic [2:0] decim(input logic [2:0] r,
                                       input logic single);
    if (r <= `FULL_RATE_IDX)
      decim = 3'h1;
    else if (r == 3'h4)
      decim = single ? `DEC_ONE_20K : `DEC_MANY_20K;
    else if (r == 3'h5)
      decim = single ? `DEC_ONE_30K : `DEC_MANY_30K;
    else
      decim = single ? `DEC_ONE_49K : `DEC_MANY_49K;
  endfunction

  function automatic logic pat_level(input led_pat_t p,
                                     input logic [6:0] ph);
    logic [6:0] on_t;
    on_t = 7'(`LED_ON_MS / `LED_TICK_MS);
    case (p)
      pat_off: pat_level = 1'b0;
      pat_on: pat_level = 1'b1;
      pat_slow: pat_level = (ph % (on_t * 7'h2)) < on_t;
      pat_fast: pat_level =
        (ph % 7'(2 * `LED_FAST_HALF_MS / `LED_TICK_MS)) <
        7'(`LED_FAST_HALF_MS / `LED_TICK_MS);
      pat_single: pat_level =
        (ph % 7'((`LED_ON_MS + `LED_SINGLE_OFF_MS) / `LED_TICK_MS))
        < on_t;
      pat_double: pat_level =
        ((ph % 7'((3 * `LED_ON_MS + `LED_DOUBLE_OFF_MS) /
                  `LED_TICK_MS)) < on_t) ||
        (((ph % 7'((3 * `LED_ON_MS + `LED_DOUBLE_OFF_MS) /
                   `LED_TICK_MS)) >= on_t * 7'h2) &&
         ((ph % 7'((3 * `LED_ON_MS + `LED_DOUBLE_OFF_MS) /
                   `LED_TICK_MS)) < on_t * 7'h3));
      default: pat_level = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [2:0] rate_sel;
  sync_mode_t mode;
  logic [4:0] os_factor;
  logic [3:0] val_mask;
  bus_state_t bstate;
  logic [2:0] red_code;
  logic [3:0] exp_mask;
  logic [4:0] exp_os;
  logic inconsistent;
  logic sm_err;
  logic [15:0] block_seq;
  logic block_ready;
  logic fill_sel;
  logic [AW-1:0] wptr;
  logic [4:0] rec_cnt;
  logic busy;
  logic [1:0] vidx;
  record_t rec;
  logic [15:0] mcnt;
  logic [15:0] s0_cnt;
  logic s0_seen;
  logic alt_phase;
  logic [2:0] dec_cnt;
  logic [31:0] led_div;
  logic [6:0] led_ph;
  logic [31:0] mem [0:2*BUF_WORDS-1];

  // ************************************************************
  // bus decode
  // ************************************************************
  wire access = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire wr = done & pwrite;
  wire hit_ctrl = paddr == `ADDR_CTRL;
  wire hit_state = paddr == `ADDR_STATE;
  wire hit_exp = paddr == `ADDR_EXPECT;
  wire hit_stat = paddr == `ADDR_STATUS;
  wire [AW-1:0] win_idx = paddr[AW+1:2];
  wire hit_win = paddr[11:8] == `WIN_BASE_NIB && paddr[1:0] == 2'b00
                 && 32'(paddr[7:2]) < BUF_WORDS;
  wire mapped = hit_ctrl | hit_state | hit_exp | hit_stat | hit_win;
  wire cfg_open = bstate == st_init || bstate == st_preop;
  wire streaming = bstate == st_safeop || bstate == st_op;
  wire mismatch = exp_mask != val_mask || exp_os != os_factor;
  wire [1:0] req_state = pwdata[`STATE_REQ_LSB +: 2];
  wire refuse = bstate == st_preop && req_state > st_preop && mismatch;
  wire [4:0] wr_os = pwdata[`CTRL_OS_LSB +: 5] == 5'h00 ? 5'h01 :
                     (32'(pwdata[`CTRL_OS_LSB +: 5]) > MAX_OS ?
                      5'(MAX_OS) : pwdata[`CTRL_OS_LSB +: 5]);
  wire [7:0] words = 8'(popcount(val_mask)) * 8'(os_factor);
  wire [31:0] stat_word = {block_seq, words, 5'h00, block_ready,
                           sm_err, inconsistent};
  wire [31:0] ctrl_word = {12'h000, val_mask, 3'h0, os_factor,
                           2'h0, mode, 1'b0, rate_sel};
  wire [31:0] win_word = (streaming && block_ready) ?
                         mem[{~fill_sel, win_idx}] : 32'h0000_0000;
  wire [31:0] rd_word =
    hit_ctrl ? ctrl_word :
    hit_state ? {21'h00_0000, red_code, 6'h00, bstate} :
    hit_exp ? {12'h000, exp_mask, 3'h0, exp_os, 8'h00} :
    hit_stat ? stat_word :
    hit_win ? win_word : 32'h0000_0000;

  // ************************************************************
  // measurement timing
  // ************************************************************
  wire [15:0] period = rate_period(rate_sel);
  wire dc = mode != free_running_mode;
  wire free_tick = mcnt == period - 16'h0001;
  wire sync_tick = sync0 & (mode == clock_synchronous_mode |
    (mode == alternating_phase_one_mode & ~alt_phase) |
    (mode == alternating_phase_two_mode & alt_phase));
  wire fire = dc ? sync_tick : free_tick;
  wire [15:0] s0_len = s0_cnt + 16'h0001;
  wire s0_bad = (s0_len > period + `SYNC_TOL_CYC) ||
                (s0_len + `SYNC_TOL_CYC < period);
  wire [2:0] dec_n = decim(rate_sel, val_mask == `RST_MASK);
  wire take = meas_valid & dec_cnt == 3'h0 & streaming & ~busy;
  wire last_v = vidx == 2'h3;
  wire blk_full = last_v & busy & (rec_cnt + 5'h01 == os_factor);

  // ************************************************************
  // indicator selection
  // ************************************************************
  wire led_pat_t green_pat =
    bstate == st_init ? pat_off :
    bstate == st_preop ? pat_slow :
    bstate == st_safeop ? pat_single : pat_on;
  wire led_pat_t red_pat =
    (sm_err | inconsistent | red_code == 3'h1) ? pat_slow :
    red_code == 3'h2 ? pat_single :
    red_code == 3'h3 ? pat_double :
    red_code == 3'h4 ? pat_fast : pat_off;

  // ************************************************************
  // APB slave
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= access;
      pslverr <= access & ~mapped;
      if (access)
        prdata <= rd_word;
    end
  end

  // ************************************************************
  // configuration and state registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_sel <= `RST_RATE;
      mode <= free_running_mode;
      os_factor <= `RST_OS;
      val_mask <= `RST_MASK;
      exp_mask <= `RST_MASK;
      exp_os <= `RST_OS;
      bstate <= st_init;
      red_code <= 3'h0;
    end
    else if (ce)
    begin
      if (wr && hit_ctrl && cfg_open)
      begin
        rate_sel <= pwdata[`CTRL_RATE_LSB +: 3];
        mode <= sync_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]);
        os_factor <= wr_os;
        val_mask <= pwdata[`CTRL_MASK_LSB +: 4] | `RST_MASK;
      end
      if (wr && hit_exp)
      begin
        exp_os <= wr_os;
        exp_mask <= pwdata[`CTRL_MASK_LSB +: 4] | `RST_MASK;
      end
      if (wr && hit_state)
      begin
        red_code <= pwdata[`STATE_RED_LSB +: 3];
        if (!refuse)
          bstate <= bus_state_t'(req_state);
      end
    end
  end

  // set wins over the write-one-to-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sm_err <= 1'b0;
    else if (ce)
    begin
      if (wr && hit_state && refuse)
        sm_err <= 1'b1;
      else if (wr && hit_stat && pwdata[`STAT_SMERR_BIT])
        sm_err <= 1'b0;
    end
  end

  // ************************************************************
  // measuring clock and sync0 check
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcnt <= 16'h0000;
      s0_cnt <= 16'h0000;
      s0_seen <= 1'b0;
      alt_phase <= 1'b0;
      inconsistent <= 1'b0;
      laser_fire <= 1'b0;
      ext_sync_oe <= 1'b0;
    end
    else if (ce)
    begin
      mcnt <= free_tick ? 16'h0000 : mcnt + 16'h0001;
      laser_fire <= fire;
      ext_sync_oe <= 1'b0;
      if (sync0)
      begin
        s0_cnt <= 16'h0000;
        s0_seen <= 1'b1;
        alt_phase <= ~alt_phase;
        if (s0_seen)
          inconsistent <= dc & s0_bad;
      end
      else
      begin
        if (s0_cnt != 16'hFFFF)
          s0_cnt <= s0_cnt + 16'h0001;
        if (!dc)
          inconsistent <= 1'b0;
      end
    end
  end

  // ************************************************************
  // block assembly, double buffered
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_cnt <= 3'h0;
      busy <= 1'b0;
      vidx <= 2'h0;
      rec <= '0;
      wptr <= '0;
      rec_cnt <= 5'h00;
      fill_sel <= 1'b0;
      block_ready <= 1'b0;
      block_seq <= 16'h0000;
    end
    else if (ce)
    begin
      if (meas_valid)
        dec_cnt <= (dec_cnt + 3'h1 >= dec_n) ? 3'h0 : dec_cnt + 3'h1;
      if (!streaming)
      begin
        busy <= 1'b0;
        wptr <= '0;
        rec_cnt <= 5'h00;
        block_ready <= 1'b0;
      end
      else if (take)
      begin
        busy <= 1'b1;
        vidx <= 2'h0;
        rec <= meas_record;
      end
      else if (busy)
      begin
        vidx <= vidx + 2'h1;
        if (val_mask[vidx])
          wptr <= wptr + 1'b1;
        if (last_v)
          busy <= 1'b0;
        if (blk_full)
        begin
          // swap even if unread: a stale block is worth less
          fill_sel <= ~fill_sel;
          wptr <= '0;
          rec_cnt <= 5'h00;
          block_ready <= 1'b1;
          block_seq <= block_seq + 16'h0001;
        end
        else if (last_v)
          rec_cnt <= rec_cnt + 5'h01;
      end
    end
  end

  // presented half is untouched until next swap
  always_ff @(posedge pclk)
  begin
    if (ce && busy && streaming && val_mask[vidx])
      mem[{fill_sel, wptr}] <= rec[32*vidx +: 32];
  end

  // ************************************************************
  // indicator
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_div <= 32'h0000_0000;
      led_ph <= 7'h00;
      leds <= '0;
    end
    else if (ce)
    begin
      if (led_div == 32'(LED_TICK_CYC - 1))
      begin
        led_div <= 32'h0000_0000;
        led_ph <= (led_ph == `LED_WRAP_TICKS - 7'h01) ? 7'h00 :
                  led_ph + 7'h01;
      end
      else
        led_div <= led_div + 32'h0000_0001;
      leds.green <= pat_level(green_pat, led_ph);
      leds.red <= pat_level(red_pat, led_ph);
    end
  end

endmodule // fieldbus_oversample_sync

// file: fb_checker_props.sv
// Purpose: port checks of the oversampling framer
// Assumes: one clock domain
// Notes: mode and sync0 parity are tracked from the ports
`timescale 1ns/100ps
`include "fb_consts.svh"
module fb_checker
  import fb_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic sync0,
  input logic laser_fire,
  input logic ext_sync_oe,
  input led_t leds
);
  // ********
  // helper state
  // ********
  logic [1:0] mode;
  logic par;
  wire ctrl_wr = psel && penable && pready && pwrite && ce
    && paddr == `ADDR_CTRL;
  // ctrl writes outside init/pre-op must keep the mode field unchanged
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode <= 2'b00;
      par <= 1'b0;
    end
    else if (ce)
    begin
      if (ctrl_wr)
        mode <= pwdata[`CTRL_MODE_LSB +: 2];
      if (sync0)
        par <= ~par;
    end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ********
  // assertions
  // ********
  property p_no_ext;
    ext_sync_oe == 1'b0;
  endproperty
  a_no_ext: assert property (p_no_ext)
    else $error("external sync pin driven");
  property p_one_wait;
    psel && penable && !pready && ce |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("apb answer not after one wait");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error answer malformed");
  property p_sync_fire;
    mode == clock_synchronous_mode && sync0 && ce |=> laser_fire;
  endproperty
  a_sync_fire: assert property (p_sync_fire)
    else $error("no fire after sync0");
  property p_alt_fire;
    mode[1] && sync0 && ce |=> laser_fire == (mode[0] == $past(par));
  endproperty
  a_alt_fire: assert property (p_alt_fire)
    else $error("alternating phase wrong");
  property p_fire_cause;
    $past(mode) != free_running_mode && laser_fire |-> $past(sync0);
  endproperty
  a_fire_cause: assert property (p_fire_cause)
    else $error("fire without sync0");
  property p_reset_quiet;
    $rose(presetn) |=> leds == 2'b00 && !pready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
endmodule // fb_checker

bind fieldbus_oversample_sync fb_checker chk_u (.pclk, .presetn, .ce,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .sync0, .laser_fire, .ext_sync_oe, .leds);

// file: fb_master.sv
// Purpose: fieldbus master polling the block over apb
// Assumes: task entered just after a rising edge
// Notes: waits for pready without limit; bench watchdog ends a hang
`timescale 1ns/100ps
module fb_master
(
  input logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines carry junk so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // fb_master

// file: fieldbus_oversample_sync_tb_top.sv
// Purpose: self-checking bench of the oversampling framer
// Assumes: short led tick of 10 cycles
// Notes: one task per scenario
`timescale 1ns/100ps
`include "fb_consts.svh"
module fieldbus_oversample_sync_tb_top import fb_pkg::*;;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic sync0, meas_valid, laser_fire, ext_sync_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  record_t meas_record;
  led_t leds;
  int failures, n_tests, fires;
  fieldbus_oversample_sync #(.LED_TICK_CYC(10)) dut_u (.pclk, .presetn,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sync0, .meas_valid, .meas_record, .laser_fire,
    .ext_sync_oe, .leds);
  fb_master m_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (laser_fire === 1'b1)
      fires++;
  // ********
  // shared tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    m_u.xfer(1'b1, a, d, q, err);
  endtask
  task automatic rd(input logic [11:0] a);
    m_u.xfer(1'b0, a, 32'h0000_0000, q, err);
  endtask
  function automatic logic [31:0] cw(input int r, m, os, k);
    return 32'(k) << 16 | 32'(os) << 8 | 32'(m) << 4 | 32'(r);
  endfunction
  task automatic send(input int k);
    meas_record <= '{{4'h4, 28'(k)}, {4'h3, 28'(k)}, {4'h2, 28'(k)},
      {4'h1, 28'(k)}};
    meas_valid <= 1'b1;
    @(posedge pclk);
    meas_valid <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic win(input int k0);
    for (int i = 0; i < 4; i++)
    begin
      rd(12'h100 + 12'(4 * i));
      chk(q, {4'(i % 2 + 1), 28'(k0 + i / 2)});
    end
  endtask
  task automatic pulses(input int n, input int gap);
    repeat (n)
    begin
      sync0 <= 1'b1;
      @(posedge pclk);
      sync0 <= 1'b0;
      repeat (gap - 1) @(posedge pclk);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset;
    int n;
    rd(`ADDR_CTRL);
    chk(q, cw(3, 0, 1, 1));
    rd(`ADDR_STATE);
    chk(q, 32'h0000_0000);
    rd(12'h010);
    chk({31'h0, err}, 32'h0000_0001);
    // free run at 10 kHz: one fire per 2500 cycles
    n = 0;
    repeat (5000)
    begin
      @(posedge pclk);
      n += int'(laser_fire === 1'b1);
    end
    chk(32'(n), 32'h0000_0002);
  endtask
  task automatic t_map;
    wr(`ADDR_STATE, 32'h0000_0001);
    wr(`ADDR_CTRL, cw(3, 0, 2, 2));
    rd(`ADDR_CTRL);
    chk(q, cw(3, 0, 2, 3));
    wr(`ADDR_STATE, 32'h0000_0002);
    rd(`ADDR_STATE);
    chk(q, 32'h0000_0001);
    rd(`ADDR_STATUS);
    chk(q & 32'h0000_0003, 32'h0000_0002);
    wr(`ADDR_STATUS, 32'h0000_0002);
    wr(`ADDR_EXPECT, cw(3, 0, 2, 3));
    rd(`ADDR_EXPECT);
    chk(q, cw(0, 0, 2, 3));
    wr(`ADDR_STATE, 32'h0000_0002);
    rd(`ADDR_STATE);
    chk(q, 32'h0000_0002);
    // mode kept at free so the checker's copy of it stays true
    wr(`ADDR_CTRL, cw(3, 0, 4, 3));
    rd(`ADDR_CTRL);
    chk(q, cw(3, 0, 2, 3));
    rd(12'h100);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_block;
    send(0);
    rd(`ADDR_STATUS);
    chk(q & 32'hFFFF_0007, 32'h0000_0000);
    send(1);
    rd(`ADDR_STATUS);
    chk(q, 32'h0001_0404);
    win(0);
    win(0);
    send(2);
    win(0);
    for (int k = 3; k < 6; k++)
      send(k);
    rd(`ADDR_STATUS);
    chk({16'h0000, q[31:16]}, 32'h0000_0003);
    win(4);
  endtask
  task automatic t_decim;
    logic [15:0] s0;
    int rt[5] = '{4, 5, 6, 4, 3};
    int dv[5] = '{1, 2, 3, 2, 1};
    int mk[5] = '{1, 1, 1, 3, 1};
    for (int j = 0; j < 5; j++)
    begin
      wr(`ADDR_STATE, 32'h0000_0001);
      wr(`ADDR_CTRL, cw(rt[j], 0, 1, mk[j]));
      wr(`ADDR_EXPECT, cw(rt[j], 0, 1, mk[j]));
      wr(`ADDR_STATE, 32'h0000_0002);
      rd(`ADDR_STATUS);
      s0 = q[31:16];
      for (int k = 0; k < 6; k++)
        send(16 + k);
      rd(`ADDR_STATUS);
      chk(32'(q[31:16] - s0), 32'(6 / dv[j]));
    end
    // clock enable low: a record offered now must be ignored
    ce <= 1'b0;
    send(30);
    ce <= 1'b1;
    @(posedge pclk);
    rd(12'h100);
    chk(q, {4'h1, 28'(21)});
  endtask
  task automatic t_leds;
    logic [31:0] sw[7] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0003,
      32'h0000_0103, 32'h0000_0203, 32'h0000_0303, 32'h0000_0403};
    int ex[7] = '{600, 200, 1200, 600, 200, 480, 600};
    int n;
    // 1200 cycles span whole periods of every pattern
    for (int j = 0; j < 7; j++)
    begin
      wr(`ADDR_STATE, sw[j]);
      repeat (2) @(posedge pclk);
      n = 0;
      repeat (1200)
      begin
        @(posedge pclk);
        n += int'(j < 3 ? leds.green === 1'b1 : leds.red === 1'b1);
      end
      chk(32'(n), 32'(ex[j]));
    end
  endtask
  task automatic t_sync;
    wr(`ADDR_STATE, 32'h0000_0001);
    for (int m = 1; m < 4; m++)
    begin
      wr(`ADDR_CTRL, cw(3, m, 1, 1));
      // let a free-run fire launched before the switch drain first
      @(posedge pclk);
      fires = 0;
      pulses(4, 2500);
      chk(32'(fires), m == 1 ? 32'h0000_0004 : 32'h0000_0002);
    end
    rd(`ADDR_STATUS);
    chk(q & 32'h0000_0001, 32'h0000_0000);
    pulses(2, 1000);
    rd(`ADDR_STATUS);
    chk(q & 32'h0000_0001, 32'h0000_0001);
  endtask
  // ********
  // main sequence and watchdog
  // ********
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    sync0 = 1'b0;
    meas_valid = 1'b0;
    meas_record = '0;
    failures = 0;
    n_tests = 0;
    fires = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_map();
    t_block();
    t_decim();
    t_leds();
    t_sync();
    stop_test();
  end
  // the run needs about 46000 cycles
  initial
  begin
    repeat (80000) @(posedge pclk);
    failures++;
    stop_test();
  end
endmodule // fieldbus_oversample_sync_tb_top
